// ===== bench/dioh_assertions.sv
`timescale 1ns/1ps
// ==========================================
// handshake checks on the shared cable
module dioh_assertions
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] addr,
    input wire logic dir,
    input wire logic strobe,
    input wire logic [31:0] data_h_o,
    input wire logic [31:0] data_h_oe,
    input wire logic [31:0] data_d_oe,
    input wire logic ack,
    input wire logic cond_bit_a,
    input wire logic cond_bit_b
);
    logic [16:0] prev;
    logic [7:0] stab_cnt;
    logic [7:0] ack_cnt;
    logic [7:0] gone_cnt;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================
    // age counters; gone starts saturated so the first transfer is not flagged
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev <= '0;
            stab_cnt <= '0;
            ack_cnt <= '0;
            gone_cnt <= 8'hFF;
        end
        else
        begin
            prev <= {addr, dir};
            stab_cnt <= ({addr, dir} != prev) ? 8'h00 : stab_cnt + {7'h0, stab_cnt != 8'hFF};
            ack_cnt <= !ack ? 8'h00 : ack_cnt + {7'h0, ack_cnt != 8'hFF};
            gone_cnt <= ack ? 8'h00 : gone_cnt + {7'h0, gone_cnt != 8'hFF};
        end
    end

    // ==========================================
    // host side
    a_setup_time: assert property ($rose(strobe) |-> stab_cnt >= 8'd71)
        else $error("strobe rose before address settled");
    a_lines_held: assert property ((strobe || ack) && $past(strobe || ack) |->
        $stable(addr) && $stable(dir) && $stable(data_h_o & data_h_oe))
        else $error("lines moved during transfer");
    a_strobe_hold: assert property ($fell(strobe) |-> ack_cnt >= 8'd60)
        else $error("strobe dropped too soon after ack");
    a_addr_hold: assert property ($changed({addr, dir}) |-> gone_cnt >= 8'd40)
        else $error("address changed too soon after ack gone");
    a_data_hold: assert property ($fell(data_h_oe[0]) |-> gone_cnt >= 8'd40)
        else $error("write data dropped too soon after ack gone");
    // ==========================================
    // unit side
    a_ack_gated: assert property ($rose(ack) |-> strobe)
        else $error("ack without strobe");
    a_ack_release: assert property ($fell(strobe) |-> ##[1:4] !ack)
        else $error("ack not released after strobe fall");
    a_stall_bound: assert property ($rose(strobe) |-> ##[1:320] ack)
        else $error("unit stalled too long");
    a_unit_quiet: assert property (!strobe && !ack |->
        !cond_bit_a && !cond_bit_b && data_d_oe == '0)
        else $error("unit drives lines while idle");
    a_write_no_drive: assert property (strobe && dir |-> data_d_oe == '0)
        else $error("unit drives data on write");

    c_write: cover property ($rose(strobe) && dir);
    c_read: cover property ($rose(strobe) && !dir);
    c_release: cover property ($fell(ack));
endmodule

// ===== bench/direct_io_strobe_handshake_tb.sv
`timescale 1ns/1ps
// ==========================================
// host and unit face each other on one cable
module direct_io_strobe_handshake_tb;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] in_word;
    logic cc_a_in;
    logic cc_b_in;
    logic [31:0] out_word;
    logic out_stb;
    logic [31:0] lfsr_q = 32'h4D6B;
    int errors;
    int compares;
    logic [31:0] exp_q[$];
    logic [31:0] model_word = 32'h0;

    dioh_link_if link();
    dioh_host u_dioh_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));
    // stall keeps the slow answer path in use
    dioh_unit #(.UNIT_ADDR(16'hC000), .NARROW_HOST(1'b0), .STALL_CYC(20)) u_dioh_unit (
        .pclk(pclk), .presetn(presetn), .in_word(in_word), .cc_a_in(cc_a_in),
        .cc_b_in(cc_b_in), .out_word(out_word), .out_stb(out_stb), .link(link));
    dioh_assertions u_chk (.pclk(pclk), .presetn(presetn), .addr(link.addr),
        .dir(link.dir), .strobe(link.strobe), .data_h_o(link.data_h_o),
        .data_h_oe(link.data_h_oe), .data_d_oe(link.data_d_oe), .ack(link.ack),
        .cond_bit_a(link.cond_bit_a), .cond_bit_b(link.cond_bit_b));

    // ==========================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; waits on pready, the watchdog bounds it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one direct transfer to the unit, checked at wire and registers
    task automatic xfer(input logic wr, input logic nosrc, input logic [1:0] sel);
        logic [31:0] r;
        logic e;
        logic [31:0] w;
        logic [15:0] a;
        w = lfsr_q;
        a = {4'hC, sel, 10'h000};
        lfsr_q = lfsr_next(lfsr_q);
        in_word <= lfsr_q;
        cc_a_in <= lfsr_q[3];
        cc_b_in <= lfsr_q[9];
        apb(1'b1, dioh_pkg::REG_WDATA, w, r, e);
        // the unit keeps the half that the select leaves out
        if (wr)
        begin
            if (sel[1])
                model_word[31:16] = nosrc ? 16'h0 : w[31:16];
            if (sel[0])
                model_word[15:0] = nosrc ? 16'h0 : w[15:0];
            exp_q.push_back(model_word);
        end
        apb(1'b1, dioh_pkg::REG_CTRL, {1'b1, wr, nosrc, 13'h0, a}, r, e);
        while (link.strobe !== 1'b1)
            @(posedge pclk);
        chk("wire dir", {31'h0, link.dir}, {31'h0, wr});
        chk("wire addr", {16'h0, link.addr}, {16'h0, a});
        chk("wire io reset", {31'h0, link.io_reset}, 32'h0);
        if (wr)
            chk("wire data", link.data, nosrc ? 32'h0 : w);
        r = 32'h0;
        while (r[dioh_pkg::ST_DONE] !== 1'b1)
            apb(1'b0, dioh_pkg::REG_STATUS, 32'h0, r, e);
        chk("cond a", {31'h0, r[dioh_pkg::ST_CCA]}, {31'h0, lfsr_q[3]});
        chk("cond b", {31'h0, r[dioh_pkg::ST_CCB]}, {31'h0, lfsr_q[9]});
        if (!wr)
        begin
            apb(1'b0, dioh_pkg::REG_RDATA, 32'h0, r, e);
            chk("read data", r, lfsr_q);
        end
        apb(1'b1, dioh_pkg::REG_STATUS, 32'h2, r, e);
    endtask

    // ==========================================
    // written words must reach the unit once each, in order
    always @(posedge pclk)
        if (presetn === 1'b1 && out_stb === 1'b1)
            chk("unit word", out_word, exp_q.size() != 0 ? exp_q.pop_front() : ~out_word);

    task automatic report_and_stop;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==========================================
    // clock, watchdog and main sequence
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // whole run needs some 1400 cycles
    initial
    begin
        #200000;
        errors++;
        report_and_stop();
    end

    initial
    begin
        logic [31:0] r;
        logic e;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        in_word = 32'h0;
        cc_a_in = 1'b0;
        cc_b_in = 1'b0;
        errors = 0;
        compares = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, dioh_pkg::REG_STATUS, 32'h0, r, e);
        chk("status after reset", {28'h0, r[3:0]}, 32'h0);
        apb(1'b0, 8'h10, 32'h0, r, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        for (int i = 0; i < 6; i++)
            xfer(i[0], i == 5, (i == 3) ? 2'b10 : ((i == 5) ? 2'b01 : 2'b11));
        repeat (10) @(posedge pclk);
        chk("words left", exp_q.size(), 32'h0);
        report_and_stop();
    end
endmodule

// ===== src/dioh_host.sv
`timescale 1ns/1ps
// host end: apb-driven direct read/write master on the cable
module dioh_host
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dioh_link_if.host link
);
    // ==========================================
    // state
    typedef enum logic [2:0]
    {
        H_IDLE = 3'h0,
        H_SETUP = 3'h1,
        H_WAIT = 3'h3,
        H_HOLD = 3'h2,
        H_RELEASE = 3'h6
    } dioh_hst_t;
    typedef struct packed
    {
        dioh_hst_t st;
        logic [8:0] cnt;
        logic [15:0] addr;
        logic dir;
        logic strobe;
        logic iorst;
        logic [31:0] wdata;
        logic [31:0] hdata;
        logic hoe;
        logic [31:0] rdata;
        logic cca;
        logic ccb;
        logic done;
        logic [6:0] div;
        logic clk1m;
        logic ack_s1;
        logic ack_s2;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dioh_hreg_t;
    dioh_hreg_t r;
    dioh_hreg_t next_r;
    logic [31:0] data_s1;
    logic [31:0] data_s2;
    logic cca_s1;
    logic cca_s2;
    logic ccb_s1;
    logic ccb_s2;
    // ==========================================
    // lines from the cable cross into pclk through two stages
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_s1 <= 32'h0;
            data_s2 <= 32'h0;
            cca_s1 <= 1'b0;
            cca_s2 <= 1'b0;
            ccb_s1 <= 1'b0;
            ccb_s2 <= 1'b0;
        end
        else
        begin
            data_s1 <= link.data;
            data_s2 <= data_s1;
            cca_s1 <= link.cond_bit_a;
            cca_s2 <= cca_s1;
            ccb_s1 <= link.cond_bit_b;
            ccb_s2 <= ccb_s1;
        end
    end
    // ==========================================
    // next-state logic
    always_comb
    begin
        logic acc;
        logic wr;
        acc = psel && penable && !r.pready;
        // writes land at the edge where the master samples pready high
        wr = psel && penable && pwrite && r.pready;
        next_r = r;
        next_r.pready = acc;
        next_r.pslverr = 1'b0;
        next_r.ack_s1 = link.ack;
        next_r.ack_s2 = r.ack_s1;
        // free-running cable clock from a divider; a slow rate, no second domain
        if (r.div == 7'(dioh_pkg::ONE_MHZ_HALF_CYC - 1))
        begin
            next_r.div = 7'h00;
            next_r.clk1m = !r.clk1m;
        end
        else
        begin
            next_r.div = r.div + 7'h01;
        end
        // register reads
        if (acc && !pwrite)
        begin
            unique case (paddr)
                dioh_pkg::REG_CTRL:
                    next_r.prdata = {3'h0, r.iorst, 11'h0, r.dir, r.addr};
                dioh_pkg::REG_WDATA: next_r.prdata = r.wdata;
                dioh_pkg::REG_STATUS:
                    next_r.prdata = {28'h0, r.ccb, r.cca, r.done, (r.st != H_IDLE)};
                dioh_pkg::REG_RDATA: next_r.prdata = r.rdata;
                default:
                begin
                    next_r.prdata = 32'h0;
                    next_r.pslverr = 1'b1;
                end
            endcase
        end
        else if (acc)
        begin
            next_r.prdata = 32'h0;
            next_r.pslverr = !(paddr inside {dioh_pkg::REG_CTRL, dioh_pkg::REG_WDATA,
                dioh_pkg::REG_STATUS, dioh_pkg::REG_RDATA});
        end
        // WDATA and CTRL writes are refused while a transfer runs
        if (wr && r.st == H_IDLE && paddr == dioh_pkg::REG_WDATA)
        begin
            next_r.wdata = pwdata;
        end
        if (wr && paddr == dioh_pkg::REG_STATUS && pwdata[dioh_pkg::ST_DONE])
        begin
            next_r.done = 1'b0;
        end
        if (wr && r.st == H_IDLE && paddr == dioh_pkg::REG_CTRL)
        begin
            next_r.iorst = pwdata[dioh_pkg::CTRL_RESET];
            if (pwdata[dioh_pkg::CTRL_GO])
            begin
                next_r.addr = pwdata[15:0];
                next_r.dir = pwdata[dioh_pkg::CTRL_DIR];
                next_r.hdata = pwdata[dioh_pkg::CTRL_NOSRC] ? 32'h0 : r.wdata;
                next_r.hoe = pwdata[dioh_pkg::CTRL_DIR];
                next_r.done = 1'b0;
                next_r.cnt = 9'h0;
                next_r.st = H_SETUP;
            end
        end
        // link sequence
        unique case (r.st)
            H_IDLE:
            begin
                next_r.strobe = 1'b0;
            end
            H_SETUP:
            begin
                // address and direction settle before the strobe rises
                if (r.cnt >= 9'(dioh_pkg::SETUP_CYC - 1))
                begin
                    next_r.strobe = 1'b1;
                    next_r.st = H_WAIT;
                end
                else
                begin
                    next_r.cnt = r.cnt + 9'h1;
                end
            end
            H_WAIT:
            begin
                // ack seen through sync; read data and cond bits sampled with it
                if (r.ack_s2)
                begin
                    next_r.cca = cca_s2;
                    next_r.ccb = ccb_s2;
                    if (!r.dir)
                    begin
                        next_r.rdata = data_s2;
                    end
                    next_r.cnt = 9'h0;
                    next_r.st = H_HOLD;
                end
            end
            H_HOLD:
            begin
                if (r.cnt >= 9'(dioh_pkg::SHOLD_CYC - 1))
                begin
                    next_r.strobe = 1'b0;
                    next_r.cnt = 9'h0;
                    next_r.st = H_RELEASE;
                end
                else
                begin
                    next_r.cnt = r.cnt + 9'h1;
                end
            end
            H_RELEASE:
            begin
                // hold time counts from ack seen gone, so it covers either reading
                if (r.ack_s2)
                begin
                    next_r.cnt = 9'h0;
                end
                else if (r.cnt < 9'(dioh_pkg::AHOLD_CYC))
                begin
                    next_r.cnt = r.cnt + 9'h1;
                end
                else
                begin
                    next_r.done = 1'b1;
                    next_r.hoe = 1'b0;
                    next_r.st = H_IDLE;
                end
            end
        endcase
    end
    // ==========================================
    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end
    // ==========================================
    // outputs; strobe and data enable rest at zero outside a transfer, addr and dir keep their last value
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign link.addr = r.addr;
    assign link.dir = r.dir;
    assign link.strobe = r.strobe;
    assign link.io_reset = r.iorst;
    assign link.one_mhz_clock_line = r.clk1m;
    assign link.data_h_o = r.hdata;
    assign link.data_h_oe = {32{r.hoe}};
endmodule

// ===== src/dioh_link_if.sv
`timescale 1ns/1ps
// shared cable lines; data lines rest at zero and any enabled driver raises them
interface dioh_link_if;
    logic [dioh_pkg::ADDR_W-1:0] addr;
    logic dir;
    logic strobe;
    logic io_reset;
    logic one_mhz_clock_line;
    logic [dioh_pkg::DATA_W-1:0] data_h_o;
    logic [dioh_pkg::DATA_W-1:0] data_h_oe;
    logic [dioh_pkg::DATA_W-1:0] data_d_o;
    logic [dioh_pkg::DATA_W-1:0] data_d_oe;
    logic [dioh_pkg::DATA_W-1:0] data;
    logic ack;
    logic cond_bit_a;
    logic cond_bit_b;
    // wired-or resolution of the data lines
    assign data = (data_h_o & data_h_oe) | (data_d_o & data_d_oe);
    modport host (output addr, dir, strobe, io_reset, one_mhz_clock_line,
        data_h_o, data_h_oe, input data, ack, cond_bit_a, cond_bit_b);
    modport unit (input addr, dir, strobe, io_reset, one_mhz_clock_line, data,
        output data_d_o, data_d_oe, ack, cond_bit_a, cond_bit_b);
endinterface

// ===== src/dioh_pkg.sv
// Functional notes
// - direction high for write, held with address
// - address stable 360 ns before strobe
// - matching unit gates read data on strobe
// - sample after ack, strobe drop 300 ns later
// - read outputs released on strobe fall
// - read address held until ack gone, 200 ns
// - write address, data held until ack gone
// - write: unit gates cond bits and ack
// - write data captured at strobe falling edge
// - write: release cond bits, ack on fall
// - unit never stalls beyond 1.6 us
// - unit decodes all sixteen address bits
// - unit drives host-owned lines at zero
// - two address bits select half words
// - narrow host: upper bits mirror lower half
// - host presents low 16 address bits
// - upper nibble is control mode field
// - no source register: host drives zeros
// - lines rest at zero, any driver raises
package dioh_pkg;
    // ==========================================
    // clock and timing
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned ADDR_SETUP_NS = 360;
    localparam int unsigned STROBE_HOLD_NS = 300;
    localparam int unsigned ADDR_HOLD_NS = 200;
    localparam int unsigned STALL_MAX_NS = 1600;
    localparam int unsigned STALL_MIN_NS = 600;
    localparam int unsigned SETUP_CYC = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned SHOLD_CYC =
        (STROBE_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned AHOLD_CYC = (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned STALL_MAX_CYC = (STALL_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned STALL_MIN_CYC =
        (STALL_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned ONE_MHZ_HALF_CYC = 100;
    localparam int CNT_W = 9;
    // ==========================================
    // line layout
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int MODE_LSB = 12;
    localparam int HOST_ONLY_ADDR_LSB = 14;
    localparam logic [3:0] MODE_INTERNAL = 4'h0;
    localparam logic [3:0] MODE_STD_LO = 4'hC;
    localparam logic [3:0] MODE_STD_HI = 4'hE;
    // half-word select bits within the unit's address
    localparam int SEL_HI_BIT = 11;
    localparam int SEL_LO_BIT = 10;
    // ==========================================
    // apb registers of the host controller
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam int CTRL_GO = 31;
    localparam int CTRL_DIR = 30;
    localparam int CTRL_NOSRC = 29;
    localparam int CTRL_RESET = 28;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_CCA = 2;
    localparam int ST_CCB = 3;
endpackage

// ===== src/dioh_unit.sv
`timescale 1ns/1ps
// peripheral end: one addressed unit with a 32-bit in and out register
module dioh_unit
#(
    parameter logic [15:0] UNIT_ADDR = 16'hC000,
    parameter bit NARROW_HOST = 1'b0,
    parameter int STALL_CYC = 0
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] in_word,
    input wire logic cc_a_in,
    input wire logic cc_b_in,
    output logic [31:0] out_word,
    output logic out_stb,
    dioh_link_if.unit link
);
    typedef struct packed
    {
        logic s1;
        logic s2;
        logic on;
        logic [8:0] cnt;
        logic rd;
        logic [31:0] rdat;
        logic [31:0] wd1;
        logic [31:0] wd2;
        logic [15:0] a1;
        logic [15:0] a2;
        logic d1;
        logic d2;
        logic [31:0] out;
        logic stb;
        logic ca;
        logic cb;
        logic doe;
    } dioh_ureg_t;
    dioh_ureg_t r;
    dioh_ureg_t next_r;
    // half-select bits sit outside the fixed part of the address
    localparam logic [15:0] SEL_MASK =
        (16'h1 << dioh_pkg::SEL_HI_BIT) | (16'h1 << dioh_pkg::SEL_LO_BIT);
    // ==========================================
    // next-state logic
    always_comb
    begin
        logic hit;
        logic [31:0] w;
        hit = 1'b0;
        w = r.out;
        next_r = r;
        next_r.s1 = link.strobe;
        next_r.s2 = r.s1;
        next_r.wd1 = link.data;
        next_r.wd2 = r.wd1;
        next_r.a1 = link.addr;
        next_r.a2 = r.a1;
        next_r.d1 = link.dir;
        next_r.d2 = r.d1;
        next_r.stb = 1'b0;
        // mode field and all other fixed bits compared, at least one half selected
        hit = (r.a2 & ~SEL_MASK) == (UNIT_ADDR & ~SEL_MASK) && (r.a2 & SEL_MASK) != 16'h0;
        if (r.s2 && hit && !r.on)
        begin
            // optional stall, capped 4 cycles short of the longest allowed
            if (r.cnt >= 9'(STALL_CYC) || r.cnt >= 9'(dioh_pkg::STALL_MAX_CYC - 4))
            begin
                next_r.on = 1'b1;
                next_r.rd = !r.d2;
                next_r.rdat = in_word;
                next_r.ca = cc_a_in;
                next_r.cb = cc_b_in;
                next_r.doe = !r.d2;
            end
            else
            begin
                next_r.cnt = r.cnt + 9'h1;
            end
        end
        if (!r.s2)
        begin
            next_r.cnt = 9'h0;
            next_r.on = 1'b0;
            next_r.ca = 1'b0;
            next_r.cb = 1'b0;
            next_r.doe = 1'b0;
            if (r.on && !r.rd)
            begin
                // trailing-edge capture with half select
                w = r.out;
                if (r.a2[dioh_pkg::SEL_HI_BIT])
                begin
                    w[31:16] = r.wd2[31:16];
                end
                if (r.a2[dioh_pkg::SEL_LO_BIT])
                begin
                    w[15:0] = NARROW_HOST ? r.wd2[31:16] : r.wd2[15:0];
                end
                next_r.out = w;
                next_r.stb = 1'b1;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end
    // ==========================================
    // outputs; host-owned lines are inputs here, so never driven
    assign out_word = r.out;
    assign out_stb = r.stb;
    assign link.ack = r.on;
    assign link.cond_bit_a = r.ca;
    assign link.cond_bit_b = r.cb;
    assign link.data_d_o = r.rdat;
    assign link.data_d_oe = {32{r.doe}};
endmodule
